/* File: hwj_pkg.sv */
package hwj_pkg;

	// block dimensions
	localparam int NUM_HW   = 3;
	localparam int NUM_AXES = 32;
	localparam int MAG_W    = 16;
	localparam int MAX_AXES_PER_HW = 3;

	// 1-pulse magnification limits
	localparam logic [15:0] MAG_MIN = 16'h0001;
	localparam logic [15:0] MAG_MAX = 16'h2710;

	// smoothing magnification limit
	localparam logic [5:0] SMOOTH_MAX = 6'h3B;

	// default torque limit in percent, and the minor error code for a refused enable
	localparam logic [15:0] TORQUE_DEFAULT = 16'h012C;
	localparam logic [15:0] MINOR_CODE     = 16'h00D6;

	// timing: one smoothing base step, counted in clock cycles
	localparam real CLK_PERIOD_NS      = 10.0;
	localparam real SMOOTH_BASE_MS     = 56.8;
	localparam int  SMOOTH_BASE_CYCLES = int'(SMOOTH_BASE_MS * 1.0e6 / CLK_PERIOD_NS);

	// register byte offsets
	localparam logic [11:0] OFS_ENABLE    = 12'h000;
	localparam logic [11:0] OFS_ERR_FLAG  = 12'h004;
	localparam logic [11:0] OFS_MINOR     = 12'h008;
	localparam logic [11:0] OFS_ACCEPT    = 12'h00C;
	localparam logic [11:0] OFS_TORQUE    = 12'h010;
	localparam logic [11:0] OFS_SEL0      = 12'h014;
	localparam logic [11:0] OFS_SMOOTH0   = 12'h020;
	localparam logic [11:0] OFS_ERRST0    = 12'h02C;
	localparam logic [11:0] OFS_MINCODE   = 12'h038;
	localparam logic [11:0] OFS_MAG0      = 12'h080;
	localparam logic [11:0] OFS_MAG_LAST  = 12'h0FC;

	// field positions
	localparam int TORQUE_GIVEN_BIT = 16;
	localparam int MAG_EFF_LSB      = 16;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// handwheel channel mode
	typedef enum logic [1:0] {HWJ_IDLE, HWJ_RUN, HWJ_DECEL} hwj_mode_t;

	// complete state of the control block
	typedef struct packed {
		logic [2:0]              p_s1;      // pulse synchroniser stage 1
		logic [2:0]              p_s2;      // pulse synchroniser stage 2
		logic [2:0]              p_s3;      // previous synced pulse
		logic [2:0]              d_s1;      // direction synchroniser stage 1
		logic [2:0]              d_s2;      // direction synchroniser stage 2
		logic [2:0]              en;        // enable flags
		logic [2:0]              en_prev;   // enable flags one cycle ago
		logic [2:0][31:0]        sel;       // axis-select words
		logic [2:0][5:0]         smooth;    // smoothing magnification
		logic [31:0][15:0]       mag;       // programmed magnification
		logic [31:0][15:0]       eff;       // magnification in use
		hwj_mode_t [2:0]         mode;      // channel mode
		logic [2:0][31:0]        owned;     // axes driven per channel
		logic [2:0][6:0]         cnt;       // deceleration base steps left
		logic                    err_flag;  // axis-setting error flag
		logic [2:0][31:0]        err_store; // axis-setting error words
		logic [31:0]             minor;     // minor error per axis
		logic                    tq_given;  // torque limit supplied
		logic [15:0]             tq_val;    // supplied torque limit
		logic [15:0]             tq_out;    // torque limit in force
		logic [31:0]             step;      // step pulses to axes
		logic [31:0]             dirv;      // step directions
		logic                    aw_ok;     // write address held
		logic [11:0]             aw_addr;
		logic                    w_ok;      // write data held
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
	} hwj_state_t;

	localparam hwj_state_t HWJ_STATE_RST = '0;

	// base-step divider state
	typedef struct packed {
		logic [22:0] cnt;
		logic        tick;
	} hwj_div_t;

	localparam hwj_div_t HWJ_DIV_RST = '0;

endpackage

/* File: hwj_tick_div.sv */
`timescale 1ns/1ps
module hwj_tick_div import hwj_pkg::*; #(
	parameter int unsigned PERIOD = SMOOTH_BASE_CYCLES
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// one-cycle pulse per base step
	output logic      tick
);

	hwj_div_t st;       // registered state
	hwj_div_t next_st;  // next state

	// count down one base step, pulse at wrap
	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		if (st.cnt == 23'h000000) begin
			next_st.cnt  = 23'(PERIOD - 1);
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt - 23'h000001;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= HWJ_DIV_RST;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// base tick is never high two cycles running
	tick_spacing_a: assert property (tick |=> !tick)
		else $error("base tick repeated");

endmodule

/* File: hwj_axis_jog.sv */
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - decel time is (smoothing plus one) times 56.8ms
// - smoothing setting 0 to 59 per handwheel
// - bad magnification flagged, replaced by one
// - smoothing time stays within 56.8 to 3408ms
// - only first three selected axes are driven
// - empty selection means no motion
// - start-accept high while axis is handwheel-driven
// - reject start requests on handwheel-driven axes
// - torque limit 300 percent unless given
// - busy axis gets error 214, ignored
// - after stop, new enable edge is accepted
// - second handwheel on claimed axis: error 214
// - re-enable during deceleration: error 214
// - other axes during deceleration: setting error
module hwj_axis_jog import hwj_pkg::*; #(
	parameter int unsigned BASE_TICK_CYCLES = SMOOTH_BASE_CYCLES
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// handwheel pins
	input  wire logic [2:0]  hw_pulse,
	input  wire logic [2:0]  hw_dir,
	// axis status and start requests from the positioning logic
	input  wire logic [31:0] axis_busy,
	input  wire logic [31:0] start_req,
	output logic [31:0]      start_ok,
	// axis outputs
	output logic [31:0]      start_accept,
	output logic [31:0]      hw_step,
	output logic [31:0]      hw_step_dir,
	output logic [15:0]      torque_limit
);

	hwj_state_t  st;        // registered state
	hwj_state_t  next_st;   // next state
	logic        tick;      // one pulse per smoothing base step
	logic [2:0]  rise_v;    // enable rising edges
	logic        eff_ok;    // helper: magnifications in use are legal

	// first three set bits, lowest first
	function automatic logic [31:0] first3(input logic [31:0] w);
		logic [31:0] r;
		int          n;
		r = '0;
		n = 0;
		for (int i = 0; i < NUM_AXES; i++) begin
			if (w[i] && n < MAX_AXES_PER_HW) begin
				r[i] = 1'b1;
				n++;
			end
		end
		return r;
	endfunction

	// byte-lane merge of a write
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// smoothing base-step divider
	hwj_tick_div #(
		.PERIOD (BASE_TICK_CYCLES)
	) u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick)
	);

	// edges of the enable flags, one compare per cycle
	assign rise_v = st.en & ~st.en_prev;

	// next-state logic: bus first, hardware sets last so sets win
	always_comb begin
		logic [31:0] claimed;
		logic [31:0] m;
		logic [31:0] take;
		logic [31:0] wv;
		logic [11:0] wa;
		logic        fall;
		int          h;
		claimed = '0;
		m       = '0;
		take    = '0;
		wv      = '0;
		wa      = '0;
		fall    = 1'b0;
		h       = 0;
		next_st = st;
		// pin synchronisers
		next_st.p_s1    = hw_pulse;
		next_st.p_s2    = st.p_s1;
		next_st.p_s3    = st.p_s2;
		next_st.d_s1    = hw_dir;
		next_st.d_s2    = st.d_s1;
		next_st.en_prev = st.en;
		next_st.step    = '0;

		// write channel: take address and data in either order
		if (s_axi_awvalid && !st.aw_ok && !st.bvalid) begin
			next_st.aw_ok   = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_ok && !st.bvalid) begin
			next_st.w_ok  = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// perform the write once both halves are held
		if (st.aw_ok && st.w_ok && !st.bvalid) begin
			next_st.aw_ok  = 1'b0;
			next_st.w_ok   = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = RESP_OKAY;
			wa             = {st.aw_addr[11:2], 2'b00};
			if (wa == OFS_ENABLE) begin
				wv         = wmerge({29'h0, st.en}, st.wdata, st.wstrb);
				next_st.en = wv[2:0];
			end else if (wa == OFS_ERR_FLAG) begin
				// write one to clear
				wv = wmerge(32'h0, st.wdata, st.wstrb);
				if (wv[0]) begin
					next_st.err_flag = 1'b0;
				end
			end else if (wa == OFS_MINOR) begin
				wv            = wmerge(32'h0, st.wdata, st.wstrb);
				next_st.minor = st.minor & ~wv;
			end else if (wa == OFS_TORQUE) begin
				// torque limit change request
				wv               = wmerge({15'h0, st.tq_given, st.tq_val}, st.wdata, st.wstrb);
				next_st.tq_given = wv[TORQUE_GIVEN_BIT];
				next_st.tq_val   = wv[15:0];
			end else if (wa >= OFS_SEL0 && wa < OFS_SMOOTH0) begin
				h              = int'((wa - OFS_SEL0) >> 2);
				next_st.sel[h] = wmerge(st.sel[h], st.wdata, st.wstrb);
			end else if (wa >= OFS_SMOOTH0 && wa < OFS_ERRST0) begin
				// out-of-range settings are held at the top of the range
				h  = int'((wa - OFS_SMOOTH0) >> 2);
				wv = wmerge({26'h0, st.smooth[h]}, st.wdata, st.wstrb);
				if (wv > {26'h0, SMOOTH_MAX}) begin
					next_st.smooth[h] = SMOOTH_MAX;
				end else begin
					next_st.smooth[h] = wv[5:0];
				end
			end else if (wa >= OFS_ERRST0 && wa < OFS_MINCODE) begin
				h                    = int'((wa - OFS_ERRST0) >> 2);
				wv                   = wmerge(32'h0, st.wdata, st.wstrb);
				next_st.err_store[h] = st.err_store[h] & ~wv;
			end else if (wa >= OFS_MAG0 && wa <= OFS_MAG_LAST) begin
				h              = int'(wa[6:2]);
				wv             = wmerge({16'h0, st.mag[h]}, st.wdata, st.wstrb);
				next_st.mag[h] = wv[15:0];
			end else if (wa != OFS_ACCEPT && wa != OFS_MINCODE) begin
				next_st.bresp = RESP_SLVERR;
			end
		end

		// read channel
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			next_st.rdata  = '0;
			wa             = {s_axi_araddr[11:2], 2'b00};
			if (wa == OFS_ENABLE) begin
				next_st.rdata = {29'h0, st.en};
			end else if (wa == OFS_ERR_FLAG) begin
				next_st.rdata = {31'h0, st.err_flag};
			end else if (wa == OFS_MINOR) begin
				next_st.rdata = st.minor;
			end else if (wa == OFS_ACCEPT) begin
				next_st.rdata = st.owned[0] | st.owned[1] | st.owned[2];
			end else if (wa == OFS_TORQUE) begin
				next_st.rdata = {15'h0, st.tq_given, st.tq_val};
			end else if (wa >= OFS_SEL0 && wa < OFS_SMOOTH0) begin
				next_st.rdata = st.sel[int'((wa - OFS_SEL0) >> 2)];
			end else if (wa >= OFS_SMOOTH0 && wa < OFS_ERRST0) begin
				next_st.rdata = {26'h0, st.smooth[int'((wa - OFS_SMOOTH0) >> 2)]};
			end else if (wa >= OFS_ERRST0 && wa < OFS_MINCODE) begin
				next_st.rdata = st.err_store[int'((wa - OFS_ERRST0) >> 2)];
			end else if (wa == OFS_MINCODE) begin
				next_st.rdata = {16'h0, MINOR_CODE};
			end else if (wa >= OFS_MAG0 && wa <= OFS_MAG_LAST) begin
				next_st.rdata = {st.eff[int'(wa[6:2])], st.mag[int'(wa[6:2])]};
			end else begin
				next_st.rresp = RESP_SLVERR;
			end
		end

		// handwheel channels; a lower channel claims first in a tie
		claimed = st.owned[0] | st.owned[1] | st.owned[2];
		for (int c = 0; c < NUM_HW; c++) begin
			m    = first3(st.sel[c]);
			fall = st.en_prev[c] & ~st.en[c];
			case (st.mode[c])
				HWJ_IDLE: begin
					// an empty selection starts nothing
					if (rise_v[c] && m != 32'h0) begin
						take          = m & ~axis_busy & ~claimed;
						next_st.minor = next_st.minor | (m & (axis_busy | claimed));
						for (int a = 0; a < NUM_AXES; a++) begin
							if (take[a]) begin
								if (st.mag[a] < MAG_MIN || st.mag[a] > MAG_MAX) begin
									next_st.eff[a]          = MAG_MIN;
									next_st.err_store[c][a] = 1'b1;
									next_st.err_flag        = 1'b1;
								end else begin
									next_st.eff[a] = st.mag[a];
								end
							end
						end
						next_st.owned[c] = take;
						claimed          = claimed | take;
						if (take != 32'h0) begin
							next_st.mode[c] = HWJ_RUN;
						end
					end
				end
				HWJ_RUN: begin
					// each rising edge of the synced pulse steps every driven axis
					if (st.p_s2[c] && !st.p_s3[c]) begin
						next_st.step = next_st.step | st.owned[c];
						next_st.dirv = (st.dirv & ~st.owned[c]) | ({32{st.d_s2[c]}} & st.owned[c]);
					end
					if (fall) begin
						next_st.mode[c] = HWJ_DECEL;
						next_st.cnt[c]  = 7'(st.smooth[c]) + 7'h01;
					end
				end
				HWJ_DECEL: begin
					if (rise_v[c]) begin
						// same axes: minor error; other axes: setting error
						next_st.minor = next_st.minor | (m & st.owned[c]);
						if ((m & ~st.owned[c]) != 32'h0) begin
							next_st.err_store[c] = next_st.err_store[c] | (m & ~st.owned[c]);
							next_st.err_flag     = 1'b1;
						end
					end
					if (tick) begin
						next_st.cnt[c] = st.cnt[c] - 7'h01;
						if (st.cnt[c] <= 7'h01) begin
							next_st.mode[c]  = HWJ_IDLE;
							next_st.owned[c] = '0;
						end
					end
				end
				default: begin
					next_st.mode[c]  = HWJ_IDLE;
					next_st.owned[c] = '0;
				end
			endcase
		end

		// torque limit in force during handwheel operation
		next_st.tq_out = st.tq_given ? st.tq_val : TORQUE_DEFAULT;
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= HWJ_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign s_axi_awready = !st.aw_ok && !st.bvalid;
	assign s_axi_wready  = !st.w_ok && !st.bvalid;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign start_accept  = st.owned[0] | st.owned[1] | st.owned[2];
	assign start_ok      = start_req & ~start_accept;
	assign hw_step       = st.step;
	assign hw_step_dir   = st.dirv;
	assign torque_limit  = st.tq_out;

	// helper: every driven axis uses a legal magnification
	always_comb begin
		eff_ok = 1'b1;
		for (int a = 0; a < NUM_AXES; a++) begin
			if (start_accept[a] && (st.eff[a] < MAG_MIN || st.eff[a] > MAG_MAX)) begin
				eff_ok = 1'b0;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// busy-axis refusal is watched on the third wheel, where the bench raises it
	sequence busy_rise_s;
		rise_v[2] && st.mode[2] == HWJ_IDLE && (first3(st.sel[2]) & axis_busy) != 32'h0;
	endsequence

	sequence decel_other_s;
		rise_v[0] && st.mode[0] == HWJ_DECEL && (first3(st.sel[0]) & ~st.owned[0]) != 32'h0;
	endsequence

	decel_load_a: assert property ($rose(st.mode[0] == HWJ_DECEL) |->
		st.cnt[0] == 7'(st.smooth[0]) + 7'h01) else $error("decel count not smoothing plus one");
	smooth_range_a: assert property (st.smooth[0] <= SMOOTH_MAX && st.smooth[1] <= SMOOTH_MAX
		&& st.smooth[2] <= SMOOTH_MAX) else $error("smoothing setting out of range");
	mag_legal_a: assert property (eff_ok)
		else $error("driven axis has illegal magnification");
	three_axes_a: assert property ($countones(st.owned[0]) <= 3)
		else $error("more than three axes driven");
	empty_sel_a: assert property ((rise_v[1] && st.mode[1] == HWJ_IDLE
		&& st.sel[1] == 32'h0) |=> st.mode[1] == HWJ_IDLE && st.owned[1] == 32'h0)
		else $error("empty selection started");
	step_accept_a: assert property ((hw_step & ~start_accept) == 32'h0)
		else $error("step on axis without start accept");
	start_reject_a: assert property ((start_ok & start_accept) == 32'h0)
		else $error("start accepted on handwheel axis");
	// sampled reset in the antecedent keeps the release edge from starting a check
	torque_dflt_a: assert property ((aresetn && !st.tq_given) |=>
		torque_limit == TORQUE_DEFAULT) else $error("default torque limit not 300");
	busy_minor_a: assert property (busy_rise_s |=>
		(st.minor & $past(first3(st.sel[2]) & axis_busy)) == $past(first3(st.sel[2]) & axis_busy))
		else $error("busy axis not given minor error");
	decel_err_a: assert property (decel_other_s |=> st.err_flag && st.mode[0] != HWJ_RUN)
		else $error("setting error missing during deceleration");

endmodule

/* File: hwj_wheel_model.sv */
`timescale 1ns/1ps
// handwheel: sends a burst of pulses on one channel, pulse pins idle low between bursts
module hwj_wheel_model import hwj_pkg::*; (
	// clock
	input  wire logic       aclk,
	// burst request from the bench
	input  wire logic       go,
	input  wire logic [1:0] ch,
	input  wire logic [7:0] n,
	input  wire logic [3:0] gap,
	// handwheel pins and burst status
	output logic [2:0]      hw_pulse,
	output logic [2:0]      hw_dir,
	output logic            busy
);
	// gap sets the pace: small is a fast turn, large a slow one
	initial begin
		hw_pulse = '0;
		hw_dir   = '0;
		busy     = 1'b0;
		forever begin
			@(posedge aclk);
			if (go) begin
				busy       <= 1'b1;
				hw_dir[ch] <= ~hw_dir[ch];
				repeat (n) begin
					repeat (gap) @(posedge aclk);
					hw_pulse[ch] <= 1'b1;
					repeat (gap) @(posedge aclk);
					hw_pulse[ch] <= 1'b0;
				end
				busy <= 1'b0;
			end
		end
	end
endmodule

/* File: handwheel_axis_jog_control_tb.sv */
`timescale 1ns/1ps
module handwheel_axis_jog_control_tb import hwj_pkg::*;;
	// short base step keeps deceleration brief
	localparam int BT = 4;
	// clock, reset and bus
	logic        aclk = 0, aresetn = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rd;
	logic [3:0]  wstrb = '0;
	logic [1:0]  bresp, rresp, rs;
	// pins, axis side and wheel control
	logic [2:0]  hw_pulse, hw_dir;
	logic [31:0] axis_busy = '0, start_req = '0, start_ok, start_accept, hw_step, step_dir;
	logic [15:0] torque_limit;
	logic        go = 0, wb;
	logic [1:0]  ch = '0;
	logic [7:0]  n = '0;
	logic [3:0]  gap = '0;
	int          mismatches = 0, tests_run = 0, steps[32];

	hwj_axis_jog #(.BASE_TICK_CYCLES(BT)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .hw_pulse(hw_pulse), .hw_dir(hw_dir),
		.axis_busy(axis_busy), .start_req(start_req), .start_ok(start_ok),
		.start_accept(start_accept), .hw_step(hw_step), .hw_step_dir(step_dir),
		.torque_limit(torque_limit));

	hwj_wheel_model u_wheel (.aclk(aclk), .go(go), .ch(ch), .n(n), .gap(gap),
		.hw_pulse(hw_pulse), .hw_dir(hw_dir), .busy(wb));

	// 100 MHz clock
	always #5 aclk = ~aclk;

	// step pulses counted mid-cycle, where they are settled
	always @(negedge aclk) begin
		for (int i = 0; i < 32; i++) begin
			if (hw_step[i] === 1'b1) steps[i]++;
		end
	end

	task automatic wrap_up();
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	task automatic hang(input string m);
		mismatches++;
		$display("MISMATCH %0t timeout %s", $time, m);
		wrap_up();
	endtask

	// bus write: both halves offered together, response awaited
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, done;
		done = 0;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		wstrb   <= 4'hF;
		bready  <= 1'b1;
		for (int k = 0; !done; k++) begin
			if (k > 50) hang("write");
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			done = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (done) bready <= 1'b0;
		end
	endtask

	// bus read, then masked compare
	task automatic rchk(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] e,
		input string m);
		logic ta, done;
		done = 0;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		for (int k = 0; !done; k++) begin
			if (k > 50) hang("read");
			@(negedge aclk);
			ta = arvalid && arready;
			done = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
		chk(rd & mk, e, m);
	endtask

	// one burst of pulses from the wheel, then let the steps land
	task automatic burst(input logic [1:0] c, input logic [7:0] cnt, input logic [3:0] g);
		@(posedge aclk);
		go  <= 1'b1;
		ch  <= c;
		n   <= cnt;
		gap <= g;
		@(posedge aclk);
		go <= 1'b0;
		for (int k = 0; wb || k < 2; k++) begin
			if (k > 999) hang("wheel");
			@(negedge aclk);
		end
		repeat (6) @(posedge aclk);
	endtask

	task automatic sc_basic();
		chk(32'(torque_limit), 32'(TORQUE_DEFAULT), "idle torque");
		rchk(OFS_MINCODE, '1, 32'(MINOR_CODE), "minor code");
		wr(OFS_MAG0, 32'd100);
		wr(OFS_MAG0 + 12'h014, 32'(MAG_MAX));
		wr(OFS_SMOOTH0, 32'd63);
		rchk(OFS_SMOOTH0, '1, 32'(SMOOTH_MAX), "smooth limit");
		wr(OFS_SEL0, 32'h0000_0225);
		wr(OFS_ENABLE, 32'h1);
		repeat (3) @(posedge aclk);
		chk(start_accept, 32'h25, "first three");
		rchk(OFS_ERRST0, '1, 32'h4, "bad mag");
		rchk(OFS_MAG0 + 12'h008, '1, 32'h0001_0000, "mag one");
		rchk(OFS_MAG0 + 12'h014, '1, 32'h2710_2710, "mag max");
		rchk(OFS_ERR_FLAG, 32'h1, 32'h1, "err flag");
		start_req <= '1;
		@(negedge aclk);
		chk(start_ok, ~32'h25, "start refused");
		@(posedge aclk);
		start_req <= '0;
		burst(2'd0, 8'd5, 4'd2);
		chk(step_dir & 32'h25, 32'h25, "dir first burst");
		burst(2'd0, 8'd3, 4'd6);
		chk(step_dir & 32'h25, 32'h0, "dir second burst");
		chk(32'(steps[0]), 32'd8, "steps 0");
		chk(32'(steps[5]), 32'd8, "steps 5");
		chk(32'(steps[9]), 32'd0, "steps 9");
		chk(32'(torque_limit), 32'(TORQUE_DEFAULT), "run torque");
	endtask

	task automatic sc_claim();
		wr(OFS_SEL0 + 12'h004, 32'h3);
		wr(OFS_ENABLE, 32'h3);
		repeat (3) @(posedge aclk);
		chk(start_accept, 32'h27, "second wheel");
		rchk(OFS_MINOR, 32'h3, 32'h1, "claimed axis");
		wr(OFS_MINOR, '1);
		wr(OFS_ERRST0, '1);
		wr(OFS_ERR_FLAG, 32'h1);
	endtask

	task automatic sc_decel();
		wr(OFS_ENABLE, 32'h0);
		repeat (3) @(posedge aclk);
		chk(32'(start_accept[0]), 32'h1, "decel accept");
		wr(OFS_ENABLE, 32'h1);
		rchk(OFS_MINOR, 32'h1, 32'h1, "decel re-enable");
		wr(OFS_ENABLE, 32'h0);
		wr(OFS_SEL0, 32'h1000);
		wr(OFS_ENABLE, 32'h1);
		repeat (3) @(posedge aclk);
		chk(32'(start_accept[12]), 32'h0, "new axis held");
		rchk(OFS_ERRST0, 32'h1000, 32'h1000, "setting store");
		rchk(OFS_ERR_FLAG, 32'h1, 32'h1, "setting flag");
		for (int k = 0; start_accept !== '0; k++) begin
			if (k > 400) hang("decel");
			@(negedge aclk);
		end
		wr(OFS_ENABLE, 32'h0);
	endtask

	task automatic sc_timing();
		int k;
		wr(OFS_SEL0, 32'h1);
		wr(OFS_ENABLE, 32'h1);
		repeat (3) @(posedge aclk);
		wr(OFS_ENABLE, 32'h0);
		for (k = 0; start_accept[0] !== 1'b0; k++) begin
			if (k > 400) hang("timing");
			@(negedge aclk);
		end
		chk(32'(k >= 59 * BT - 6 && k <= 60 * BT + 5), 32'h1, "decel time");
	endtask

	task automatic sc_busy();
		wr(OFS_MINOR, '1);
		axis_busy <= 32'h0010_0000;
		wr(OFS_SEL0 + 12'h008, 32'h0010_0000);
		wr(OFS_ENABLE, 32'h4);
		repeat (3) @(posedge aclk);
		chk(start_accept, 32'h0, "busy axis");
		rchk(OFS_MINOR, '1, 32'h0010_0000, "busy minor");
		axis_busy <= '0;
		wr(OFS_ENABLE, 32'h0);
		chk(start_accept, 32'h0, "accept low first");
		wr(OFS_ENABLE, 32'h4);
		repeat (3) @(posedge aclk);
		chk(start_accept, 32'h0010_0000, "after stop");
		burst(2'd2, 8'd4, 4'd3);
		chk(32'(steps[20]), 32'd4, "steps 20");
	endtask

	task automatic sc_empty();
		wr(OFS_MINOR, '1);
		wr(OFS_SEL0 + 12'h004, 32'h0);
		wr(OFS_ENABLE, 32'h6);
		repeat (3) @(posedge aclk);
		chk(start_accept, 32'h0010_0000, "empty select");
		rchk(OFS_MINOR, '1, 32'h0, "empty minor");
		burst(2'd1, 8'd3, 4'd2);
		chk(32'(steps[1]), 32'd0, "empty steps");
		wr(OFS_ENABLE, 32'h0);
	endtask

	task automatic sc_bus();
		wr(OFS_TORQUE, 32'h0001_0064);
		repeat (3) @(posedge aclk);
		chk(32'(torque_limit), 32'h64, "given torque");
		wr(12'h040, 32'h0);
		chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
		rchk(12'h040, '1, 32'h0, "unmapped read");
		chk(32'(rs), 32'(RESP_SLVERR), "unmapped resp");
	endtask

	// reset, then the scenarios in turn
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		// torque output leaves its reset value one edge after release
		repeat (2) @(posedge aclk);
		sc_basic();
		sc_claim();
		sc_decel();
		sc_timing();
		sc_busy();
		sc_empty();
		sc_bus();
		wrap_up();
	end
endmodule
